// file: hdl/adcc_clock_halver.sv
// effective sample clock: pass-through or rising-edge divide by two
`timescale 1ns/1ns
module adcc_clock_halver (
    input  wire logic mclk,     // system clock
    input  wire logic sys_rst,  // synchronous reset, active high
    input  wire logic halveEn,  // divide by two when high
    input  wire logic inLevel,  // synchronised sample clock level
    input  wire logic inRise,   // one-cycle pulse on its rising edge
    output logic      effLevel, // effective sample clock level
    output logic      effRise   // one-cycle pulse, effective rising edge
);

    logic phase;

    // only rising input edges move the phase, so both halves are equal
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            phase <= 1'h0;
        end else if (inRise) begin
            phase <= ~phase;
        end
    end

    always_comb begin
        if (halveEn) begin
            effLevel = phase;
            effRise  = inRise & ~phase;
        end else begin
            effLevel = inLevel;
            effRise  = inRise;
        end
    end

endmodule : adcc_clock_halver

// file: hdl/adcc_delay_line.sv
// sample pipeline stages that advance once per effective sample clock
`timescale 1ns/1ns
module adcc_delay_line #(
    parameter int DEPTH = adcc_pkg::RAW_LATENCY
) (
    input  wire logic                  mclk,    // system clock
    input  wire logic                  sys_rst, // synchronous reset, active high
    input  wire logic                  advance, // shift one stage
    input  wire adcc_pkg::adcc_sample_t dIn,    // entering sample
    output adcc_pkg::adcc_sample_t     dOut     // sample leaving the last stage
);

    adcc_pkg::adcc_sample_t stage [DEPTH];

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_stage
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    stage[i] <= '0;
                end else if (advance) begin
                    if (i == 0) begin
                        stage[i] <= dIn;
                    end else begin
                        stage[i] <= stage[(i == 0) ? 0 : i - 1];
                    end
                end
            end
        end
    endgenerate

    assign dOut = stage[DEPTH-1];

endmodule : adcc_delay_line

// file: hdl/adcc_pkg.sv
// constants, types and register map for the converter output and calibration control
package adcc_pkg;

    localparam int WORD_W        = 10;
    localparam int RAW_LATENCY   = 24;
    localparam int TOTAL_LATENCY = 28;
    // loading the first stage is cycle zero, so the held word register lands on cycle 28
    localparam int CORR_STAGES   = TOTAL_LATENCY - RAW_LATENCY;

    localparam int CLK_FREQ_KHZ  = 10000;
    localparam int CAL_TIME_MS   = 240;
    localparam int CAL_CYCLES    = CAL_TIME_MS * CLK_FREQ_KHZ;
    localparam int OE_TRAIL      = 2;

    localparam int AXI_ADDR_W    = 8;
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_STATUS     = 8'h04;
    localparam logic [7:0] REG_CAL_REMAIN = 8'h08;
    localparam logic [7:0] REG_WORD_COUNT = 8'h0c;

    localparam int CTRL_RECAL      = 0;
    localparam int STAT_CAL        = 0;
    localparam int STAT_PIN_LOW    = 1;
    localparam int STAT_HALVING    = 2;
    localparam int STAT_SIGNED     = 3;
    localparam int STAT_EXT_REF    = 4;
    localparam int STAT_OVER_RANGE = 5;
    localparam int STAT_POWER_UP   = 6;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // idle values of the strap pins, as their pad pulls leave them
    localparam logic HALVE_SEL_N_RST = 1'h0;
    localparam logic FORMAT_SEL_N_RST = 1'h1;
    localparam logic REF_SEL_RST     = 1'h1;
    localparam logic CAL_PIN_N_RST   = 1'h1;

    localparam logic [WORD_W-1:0] SIGN_FLIP = 10'h200;

    typedef struct packed {
        logic              overRange;
        logic [WORD_W-1:0] word;
    } adcc_sample_t;

    typedef enum logic [1:0] {
        CAL_HOLD,
        CAL_RUN,
        CAL_DONE
    } adcc_cal_state_t;

endpackage : adcc_pkg

// file: hdl/adcc_top.sv
// converter output formatting, sample clock handling and calibration control
`timescale 1ns/1ns
module adcc_top #(
    parameter int unsigned CAL_CYCLES = adcc_pkg::CAL_CYCLES
) (
    input  wire logic                           mclk,                    // system clock, 10 MHz
    input  wire logic                           sys_rst,                 // synchronous reset, active high
    // axi4-lite slave
    input  wire logic [adcc_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,           // write address
    input  wire logic                           s_axi_awvalid,           // write address valid
    output logic                                s_axi_awready,           // write address ready
    input  wire logic [31:0]                    s_axi_wdata,             // write data
    input  wire logic [3:0]                     s_axi_wstrb,             // write byte strobes
    input  wire logic                           s_axi_wvalid,            // write data valid
    output logic                                s_axi_wready,            // write data ready
    output logic [1:0]                          s_axi_bresp,             // write response
    output logic                                s_axi_bvalid,            // write response valid
    input  wire logic                           s_axi_bready,            // write response ready
    input  wire logic [adcc_pkg::AXI_ADDR_W-1:0] s_axi_araddr,           // read address
    input  wire logic                           s_axi_arvalid,           // read address valid
    output logic                                s_axi_arready,           // read address ready
    output logic [31:0]                         s_axi_rdata,             // read data
    output logic [1:0]                          s_axi_rresp,             // read response
    output logic                                s_axi_rvalid,            // read data valid
    input  wire logic                           s_axi_rready,            // read data ready
    // converter core
    input  wire logic [adcc_pkg::WORD_W-1:0]    analogSampleWord,        // quantiser result, offset binary
    input  wire logic                           analogOverRange,         // quantiser over-range
    // pins
    input  wire logic                           sample_clock_in_true,    // sample clock, true leg
    input  wire logic                           sample_clock_in_comp,    // sample clock, complement leg
    input  wire logic                           halve_clock_select_n,    // divide by two when low
    input  wire logic                           signed_format_select_n,  // two's complement when low
    input  wire logic                           reference_source_select, // 0 internal, 1 external
    input  wire logic                           calResetIn_n,            // calibration reset pin level
    output logic                                calResetOut_n,           // pin drive value, always low
    output logic                                calResetOe,              // pin driven low while high
    output logic [adcc_pkg::WORD_W-1:0]         sampleWordTrue,          // output word, true legs
    output logic [adcc_pkg::WORD_W-1:0]         sampleWordComp,          // output word, complement legs
    output logic                                over_range_flag_true,    // over-range, true leg
    output logic                                over_range_flag_comp,    // over-range, complement leg
    output logic                                forwarded_clock_true,    // output clock, true leg
    output logic                                forwarded_clock_comp,    // output clock, complement leg
    output logic                                internalRefEnable        // internal reference selected
);

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic clkTSync1, clkTSync2, clkCSync1, clkCSync2;
    logic calPinSync1, calPinSync2;
    logic halveSync1, halveSync2, fmtSync1, fmtSync2, refSync1, refSync2;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            clkTSync1 <= 1'h0;
            clkTSync2 <= 1'h0;
            clkCSync1 <= 1'h1;
            clkCSync2 <= 1'h1;
        end else begin
            clkTSync1 <= sample_clock_in_true;
            clkTSync2 <= clkTSync1;
            clkCSync1 <= sample_clock_in_comp;
            clkCSync2 <= clkCSync1;
        end
    end

    // straps start from their pulled levels so an open pin reads its default
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            calPinSync1 <= adcc_pkg::CAL_PIN_N_RST;
            calPinSync2 <= adcc_pkg::CAL_PIN_N_RST;
            halveSync1  <= adcc_pkg::HALVE_SEL_N_RST;
            halveSync2  <= adcc_pkg::HALVE_SEL_N_RST;
            fmtSync1    <= adcc_pkg::FORMAT_SEL_N_RST;
            fmtSync2    <= adcc_pkg::FORMAT_SEL_N_RST;
            refSync1    <= adcc_pkg::REF_SEL_RST;
            refSync2    <= adcc_pkg::REF_SEL_RST;
        end else begin
            calPinSync1 <= calResetIn_n;
            calPinSync2 <= calPinSync1;
            halveSync1  <= halve_clock_select_n;
            halveSync2  <= halveSync1;
            fmtSync1    <= signed_format_select_n;
            fmtSync2    <= fmtSync1;
            refSync1    <= reference_source_select;
            refSync2    <= refSync1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sample clock edges

    logic rxLevel, rxPrev, rxRise, effLevel, effRise;

    // an invalid pair with both legs equal reads as low
    assign rxLevel = clkTSync2 & ~clkCSync2;
    assign rxRise  = rxLevel & ~rxPrev;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rxPrev <= 1'h0;
        end else begin
            rxPrev <= rxLevel;
        end
    end

    adcc_clock_halver u_halver (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .halveEn (~halveSync2),
        .inLevel (rxLevel),
        .inRise  (rxRise),
        .effLevel(effLevel),
        .effRise (effRise)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // calibration control

    adcc_pkg::adcc_cal_state_t calState;
    logic [31:0]               calRemain;
    logic                      powerUpDrive;
    logic [adcc_pkg::OE_TRAIL-1:0] oeTrail;
    logic                      recalPulse;
    logic                      pinLowValid;
    logic                      calibrating;

    // our own drive still shows in the synchroniser for a few cycles after release
    assign pinLowValid = ~calPinSync2 & ~powerUpDrive & (oeTrail == '0);
    assign calibrating = (calState != adcc_pkg::CAL_DONE);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            oeTrail <= '1;
        end else begin
            oeTrail <= {oeTrail[adcc_pkg::OE_TRAIL-2:0], calResetOe};
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            calState     <= adcc_pkg::CAL_RUN;
            calRemain    <= CAL_CYCLES;
            powerUpDrive <= 1'h1;
        end else begin
            case (calState)
                adcc_pkg::CAL_HOLD: begin
                    if (calPinSync2 && !recalPulse) begin
                        calState  <= adcc_pkg::CAL_RUN;
                        calRemain <= CAL_CYCLES;
                    end
                end
                adcc_pkg::CAL_RUN: begin
                    if (pinLowValid || recalPulse) begin
                        calState <= adcc_pkg::CAL_HOLD;
                    end else if (calRemain <= 32'h1) begin
                        calState     <= adcc_pkg::CAL_DONE;
                        calRemain    <= 32'h0;
                        powerUpDrive <= 1'h0;
                    end else begin
                        calRemain <= calRemain - 32'h1;
                    end
                end
                adcc_pkg::CAL_DONE: begin
                    if (pinLowValid || recalPulse) begin
                        calState <= adcc_pkg::CAL_HOLD;
                    end
                end
                default: begin
                    calState <= adcc_pkg::CAL_HOLD;
                end
            endcase
        end
    end

    // open-drain style: the pin is only ever pulled low, never driven high
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            calResetOut_n <= 1'h0;
            calResetOe    <= 1'h1;
        end else begin
            calResetOut_n <= 1'h0;
            calResetOe    <= powerUpDrive;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sample pipeline

    adcc_pkg::adcc_sample_t sampleIn, rawOut, corrOut, heldWord;

    assign sampleIn.overRange = analogOverRange;
    assign sampleIn.word      = analogSampleWord;

    adcc_delay_line #(
        .DEPTH(adcc_pkg::RAW_LATENCY)
    ) u_raw_pipe (
        .mclk   (mclk),
        .sys_rst(sys_rst),
        .advance(effRise),
        .dIn    (sampleIn),
        .dOut   (rawOut)
    );

    adcc_delay_line #(
        .DEPTH(adcc_pkg::CORR_STAGES)
    ) u_corr_pipe (
        .mclk   (mclk),
        .sys_rst(sys_rst),
        .advance(effRise),
        .dIn    (rawOut),
        .dOut   (corrOut)
    );

    // last stage, updated once per effective sample clock
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            heldWord <= '0;
        end else if (effRise) begin
            heldWord <= corrOut;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // output pins

    logic fwdEnable;
    logic [adcc_pkg::WORD_W-1:0] formatted;

    assign formatted = fmtSync2 ? heldWord.word : (heldWord.word ^ adcc_pkg::SIGN_FLIP);

    // the clock restarts only on a real input edge, never mid-period
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fwdEnable <= 1'h0;
        end else if (calState == adcc_pkg::CAL_HOLD || powerUpDrive) begin
            fwdEnable <= 1'h0;
        end else if (rxRise) begin
            fwdEnable <= 1'h1;
        end
    end

    // words change on the effective rising edge; the forwarded clock rises half a period later
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            forwarded_clock_true <= 1'h0;
            forwarded_clock_comp <= 1'h1;
        end else begin
            forwarded_clock_true <= fwdEnable & calPinSync2 & ~effLevel;
            forwarded_clock_comp <= ~(fwdEnable & calPinSync2 & ~effLevel);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sampleWordTrue <= '0;
            sampleWordComp <= '1;
        end else begin
            sampleWordTrue <= formatted;
            sampleWordComp <= ~formatted;
        end
    end

    // over-range follows the pin at once, not the sample clock
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            over_range_flag_true <= 1'h1;
            over_range_flag_comp <= 1'h0;
        end else begin
            over_range_flag_true <= calibrating | ~calPinSync2 | heldWord.overRange;
            over_range_flag_comp <= ~(calibrating | ~calPinSync2 | heldWord.overRange);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            internalRefEnable <= 1'h0;
        end else begin
            internalRefEnable <= ~refSync2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // delivered word counter

    logic [31:0] wordCount;

    always_ff @(posedge mclk) begin
        if (sys_rst || calibrating) begin
            wordCount <= 32'h0;
        end else if (effRise) begin
            wordCount <= wordCount + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel

    logic                           awHeld, wHeld;
    logic [adcc_pkg::AXI_ADDR_W-1:0] awAddrHeld;
    logic [31:0]                    wDataHeld;
    logic [3:0]                     wStrbHeld;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_axi_awready <= 1'h1;
            s_axi_wready  <= 1'h1;
            s_axi_bvalid  <= 1'h0;
            s_axi_bresp   <= adcc_pkg::RESP_OKAY;
            awHeld        <= 1'h0;
            wHeld         <= 1'h0;
            awAddrHeld    <= '0;
            wDataHeld     <= 32'h0;
            wStrbHeld     <= 4'h0;
            recalPulse    <= 1'h0;
        end else begin
            recalPulse <= 1'h0;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld        <= 1'h1;
                awAddrHeld    <= s_axi_awaddr;
                s_axi_awready <= 1'h0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld        <= 1'h1;
                wDataHeld    <= s_axi_wdata;
                wStrbHeld    <= s_axi_wstrb;
                s_axi_wready <= 1'h0;
            end
            if (awHeld && wHeld && !s_axi_bvalid) begin
                awHeld       <= 1'h0;
                wHeld        <= 1'h0;
                s_axi_bvalid <= 1'h1;
                case ({awAddrHeld[7:2], 2'h0})
                    adcc_pkg::REG_CTRL: begin
                        s_axi_bresp <= adcc_pkg::RESP_OKAY;
                        recalPulse  <= wStrbHeld[0] & wDataHeld[adcc_pkg::CTRL_RECAL];
                    end
                    adcc_pkg::REG_STATUS, adcc_pkg::REG_CAL_REMAIN, adcc_pkg::REG_WORD_COUNT: begin
                        s_axi_bresp <= adcc_pkg::RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= adcc_pkg::RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'h0;
                s_axi_awready <= 1'h1;
                s_axi_wready  <= 1'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel

    logic [31:0] statusWord;

    always_comb begin
        statusWord                            = 32'h0;
        statusWord[adcc_pkg::STAT_CAL]        = calibrating;
        statusWord[adcc_pkg::STAT_PIN_LOW]    = ~calPinSync2;
        statusWord[adcc_pkg::STAT_HALVING]    = ~halveSync2;
        statusWord[adcc_pkg::STAT_SIGNED]     = ~fmtSync2;
        statusWord[adcc_pkg::STAT_EXT_REF]    = refSync2;
        statusWord[adcc_pkg::STAT_OVER_RANGE] = heldWord.overRange;
        statusWord[adcc_pkg::STAT_POWER_UP]   = powerUpDrive;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'h1;
            s_axi_rvalid  <= 1'h0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= adcc_pkg::RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'h0;
                s_axi_rvalid  <= 1'h1;
                s_axi_rresp   <= adcc_pkg::RESP_OKAY;
                case ({s_axi_araddr[7:2], 2'h0})
                    adcc_pkg::REG_CTRL:       s_axi_rdata <= 32'h0;
                    adcc_pkg::REG_STATUS:     s_axi_rdata <= statusWord;
                    adcc_pkg::REG_CAL_REMAIN: s_axi_rdata <= calRemain;
                    adcc_pkg::REG_WORD_COUNT: s_axi_rdata <= wordCount;
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= adcc_pkg::RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'h0;
                s_axi_arready <= 1'h1;
            end
        end
    end

endmodule : adcc_top

// file: sim/adcc_capture_model.sv
// capture side: sample clock source, reset pin pull and word register
`timescale 1ns/1ns
module adcc_capture_model (
    input  wire logic       fwdClk,  // forwarded clock
    input  wire logic [9:0] word,    // sample word
    input  wire logic       pullReq, // recalibration wanted
    output logic            sclk,    // sample clock
    output logic [9:0]      idx,     // sample index
    output logic            calPull, // pulls pin low
    output logic [9:0]      capWord, // captured word
    output logic [9:0]      capRef   // index at capture
);
    initial {sclk, idx} = 11'h0;
    // fixed rate, so no rate change ever owes a recalibration
    always #400 sclk = ~sclk;
    always @(posedge sclk) idx <= idx + 10'h1;
    // pull only, never drive high: the device shares the pin
    assign calPull = pullReq;
    always @(posedge fwdClk) {capWord, capRef} <= {word, idx};
endmodule : adcc_capture_model

// file: sim/adcc_props.sv
// port checks of the converter control top
`timescale 1ns/1ns
module adcc_props (
    input wire logic       mclk,                    // clk
    input wire logic       sys_rst,                 // reset
    input wire logic       calResetIn_n,            // pin
    input wire logic       calResetOe,              // pin pull
    input wire logic       reference_source_select, // ref
    input wire logic       internalRefEnable,       // ref on
    input wire logic       over_range_flag_true,    // flag
    input wire logic       over_range_flag_comp,    // flag inv
    input wire logic       forwarded_clock_true,    // clk out
    input wire logic       forwarded_clock_comp,    // clk inv
    input wire logic [9:0] sampleWordTrue,          // word
    input wire logic [9:0] sampleWordComp           // word inv
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    AST_PWR: assert property ($fell(sys_rst) |-> calResetOe [*8])
        else $error("pin not held");
    // two sync stages plus the output register
    AST_ORF: assert property ($fell(calResetIn_n) && !calResetOe |-> ##3 over_range_flag_true)
        else $error("flag late");
    AST_ORH: assert property (!calResetIn_n [*4] |-> over_range_flag_true)
        else $error("flag low");
    AST_FWD: assert property (!calResetIn_n [*4] |-> !forwarded_clock_true)
        else $error("clock runs");
    AST_REF: assert property ($stable(reference_source_select) [*4] |-> internalRefEnable != reference_source_select)
        else $error("bad ref");
    AST_ORC: assert property (over_range_flag_comp != over_range_flag_true)
        else $error("flag legs");
    AST_FWC: assert property (forwarded_clock_comp != forwarded_clock_true)
        else $error("clock legs");
    AST_WDC: assert property (sampleWordComp == ~sampleWordTrue)
        else $error("word legs");
endmodule : adcc_props
////////////////////////////////////////
bind adcc_top adcc_props chk (.*);

// file: sim/tb.sv
// bench for the converter control
`timescale 1ns/1ns
module tb;
    logic        mclk = 1'h0, sys_rst = 1'h1, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, analogOverRange, calPull;
    logic        sample_clock_in_true, sample_clock_in_comp, halve_clock_select_n, signed_format_select_n, pullReq;
    logic        reference_source_select, calResetIn_n, calResetOut_n, calResetOe, internalRefEnable;
    logic        over_range_flag_true, over_range_flag_comp, forwarded_clock_true, forwarded_clock_comp;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [3:0]  s_axi_wstrb;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [9:0]  analogSampleWord = 10'h0, sampleWordTrue, sampleWordComp, capWord, capRef, idx, e;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    int          fails = 0, testsRun = 0;
    always #50 mclk = ~mclk;
    assign calResetIn_n = !(calResetOe | calPull);
    assign sample_clock_in_comp = ~sample_clock_in_true;
    always @(posedge mclk) analogSampleWord <= idx;
    adcc_top #(.CAL_CYCLES(50)) dut (.*);
    adcc_capture_model cap (.fwdClk(forwarded_clock_true), .word(sampleWordTrue), .pullReq,
        .sclk(sample_clock_in_true), .idx, .calPull, .capWord, .capRef);
    task chk(input logic [31:0] g, x);
        testsRun++;
        if (g !== x) begin
            fails++;
            $display("unexpected at %0t: %h %h", $time, g, x);
        end
    endtask : chk
    task axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 4'hf, 3'h7};
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
    endtask : axw
    task axr(input logic [7:0] a);
        @(posedge mclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        {rsp, rd} = {s_axi_rresp, s_axi_rdata};
        s_axi_rready <= 1'h0;
    endtask : axr
    task grab;
        @(posedge forwarded_clock_true);
        @(posedge mclk);
        e = capRef - 10'd28;
    endtask : grab
    task end_sim;
        $display("checks %0d mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    initial begin
        #1000000;
        fails++;
        end_sim;
    end
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, pullReq, analogOverRange} <= 7'h0;
        {halve_clock_select_n, signed_format_select_n, reference_source_select} <= 3'h7;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'h0;
        repeat (320) @(posedge mclk);
        axr(8'h04);
        chk(rd, 32'h10);
        chk(32'({calResetOut_n, calResetOe}), 32'h0);
        grab;
        chk(32'(capWord), 32'(e));
        signed_format_select_n <= 1'h0;
        repeat (300) @(posedge mclk);
        grab;
        chk(32'(capWord), 32'(e ^ 10'h200));
        {halve_clock_select_n, signed_format_select_n, reference_source_select} <= 3'h2;
        repeat (600) @(posedge mclk);
        grab;
        rd = 32'(capRef);
        grab;
        chk(32'(capRef) - rd, 32'h2);
        $display("stream tests done");
        {halve_clock_select_n, analogOverRange, pullReq} <= 3'h7;
        repeat (9) @(posedge mclk);
        pullReq <= 1'h0;
        axr(8'h04);
        chk(rd & 32'h3, 32'h3);
        repeat (300) @(posedge mclk);
        axr(8'h04);
        chk(rd & 32'h21, 32'h20);
        chk(32'(over_range_flag_true), 32'h1);
        axw(8'h00, 32'h1);
        axr(8'h04);
        chk(rd & 32'h1, 32'h1);
        axr(8'h40);
        chk(32'(rsp), 32'h2);
        $display("calibration tests done");
        end_sim;
    end
endmodule : tb
